// ==== src/dmc_pkg.sv ====
package dmc_pkg;
  localparam int ROW_W   = 8;
  localparam int COL_W   = 8;
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 4;
  localparam int CLK_MHZ = 40;
  // times in ns, counts rounded: least times up
  localparam int T_RAS_NS  = 150;
  localparam int T_RP_NS   = 100;
  localparam int T_RAH_NS  = 15;
  localparam int T_CAS_NS  = 75;
  localparam int T_RAC_NS  = 150;
  localparam int T_FCS_NS  = 30;
  localparam int T_OFD_NS  = 40;
  localparam int T_WP_NS   = 30;
  localparam int C_RAS  = (T_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int C_RP   = (T_RP_NS  * CLK_MHZ + 999) / 1000;
  localparam int C_RAH  = (T_RAH_NS * CLK_MHZ + 999) / 1000;
  localparam int C_CAS  = (T_CAS_NS * CLK_MHZ + 999) / 1000;
  localparam int C_RAC  = (T_RAC_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int C_FCS  = (T_FCS_NS * CLK_MHZ + 999) / 1000;
  localparam int C_OFD  = (T_OFD_NS * CLK_MHZ + 999) / 1000;
  localparam int C_WP   = (T_WP_NS  * CLK_MHZ + 999) / 1000;
  localparam int REF_PERIOD_US = 4000;
  localparam int REF_ROWS      = 256;
  localparam int REF_INTERVAL  = (REF_PERIOD_US * CLK_MHZ) / REF_ROWS;
  localparam int INIT_PAUSE_US = 100;
  localparam int INIT_PAUSE    = INIT_PAUSE_US * CLK_MHZ;
  localparam int INIT_CYCLES   = 8;
  localparam int CNT_W         = 8;

  typedef enum logic [1:0] {
    DMC_OP_READ  = 2'h0,
    DMC_OP_WRITE = 2'h1,
    DMC_OP_RMW   = 2'h2
  } dmc_op_t;

  typedef struct packed {
    dmc_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } dmc_req_t;

  typedef struct packed {
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic                oe_n;
    logic [ROW_W-1:0]    addr;
  } dmc_pins_t;
endpackage

// ==== src/dmc_timer.sv ====
module dmc_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_q <= value;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

  // done must not look at load: load is decided from done, which would close a loop
  assign done = (cnt_q == '0);
endmodule // dmc_timer

// ==== src/dmc_ctrl.sv ====
// Operation
// - drive row address, then drop row strobe
// - drive column address, then drop column strobe
// - early write: enable low before column
// - raise output enable before driving data
// - page mode keeps row strobe low
// - refresh all 256 rows every 4 ms
// - hidden refresh keeps column low; not done here: refresh only starts from idle, column strobe falling before row
// - counter test procedure run by software
// - pause then eight row cycles first
module dmc_ctrl #(
  parameter int INIT_PAUSE_CYC = dmc_pkg::INIT_PAUSE,
  parameter int REF_INT_CYC    = dmc_pkg::REF_INTERVAL
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire dmc_pkg::dmc_req_t          req,
  input  wire logic                       page_hold,
  output logic                            rsp_valid,
  output logic [dmc_pkg::DATA_W-1:0]      rsp_data,
  output logic                            init_done,
  output dmc_pkg::dmc_pins_t              pins,
  input  wire logic [dmc_pkg::DATA_W-1:0] dq_in,
  output logic [dmc_pkg::DATA_W-1:0]      dq_out,
  output logic                            dq_oe_n
);
  typedef enum logic [11:0] {
    ST_PAUSE  = 12'h001,
    ST_IRAS   = 12'h002,
    ST_IPRE   = 12'h004,
    ST_IDLE   = 12'h008,
    ST_ROW    = 12'h010,
    ST_COL    = 12'h020,
    ST_ACC    = 12'h040,
    ST_WEN    = 12'h080,
    ST_CLOSE  = 12'h100,
    ST_PRE    = 12'h200,
    ST_RCAS   = 12'h400,
    ST_RRAS   = 12'h800
  } dmc_state_t;

  localparam int TW = 24;
  localparam int RW = $clog2(REF_INT_CYC + 1) + 1;

  dmc_state_t          state_q;
  dmc_pkg::dmc_req_t   cur_q;
  dmc_pkg::dmc_pins_t  pins_q;
  logic [3:0]          dq_sync1_q;
  logic                pause_done_q;
  logic                page_hit;
  logic [3:0]          dq_sync2_q;
  logic [3:0]          init_cnt_q;
  logic [RW-1:0]       ref_cnt_q;
  logic                ref_due_q;
  logic                t_load;
  logic [TW-1:0]       t_val;
  logic                t_done;
  logic [3:0]          dq_out_q;
  logic                dq_oe_n_q;
  logic [3:0]          rsp_q;
  logic                rsp_v_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  function automatic logic [TW-1:0] cyc(input int n);
    cyc = (n > 1) ? TW'(n - 1) : '0;
  endfunction

  dmc_timer #(.W(TW)) u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .load  (t_load),
    .value (t_val),
    .done  (t_done)
  );

  // pin data crosses in asynchronously, two stages before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dq_sync1_q <= '0;
      dq_sync2_q <= '0;
    end else if (ce) begin
      dq_sync1_q <= dq_in;
      dq_sync2_q <= dq_sync1_q;
    end
  end

  // refresh pacing: one row per interval covers 256 rows in 4 ms
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt_q <= '0;
      ref_due_q <= 1'b0;
    end else if (ce && init_done) begin // pacing starts once the start-up cycles are over
      if (ref_cnt_q == RW'(REF_INT_CYC - 1)) begin
        ref_cnt_q <= '0;
        ref_due_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + RW'(1);
        if (state_q == ST_RCAS) begin
          ref_due_q <= 1'b0;
        end
      end
    end
  end

  // a page continuation is taken in close, so ready must show it there too
  assign page_hit  = page_hold && !ref_due_q && (req.addr[15:8] == cur_q.addr[15:8]);
  assign req_ready = t_done && ((state_q == ST_IDLE && !ref_due_q) || (state_q == ST_CLOSE && page_hit));

  // every step reloads the timer; idle only when work starts, precharge states just drain it
  always_comb begin
    t_load = t_done;
    t_val  = '0;
    case (state_q)
      ST_PAUSE: t_val = pause_done_q ? cyc(dmc_pkg::C_RAS) : cyc(INIT_PAUSE_CYC);
      ST_IRAS, ST_WEN, ST_CLOSE, ST_RRAS: t_val = cyc(dmc_pkg::C_RP);
      ST_IDLE: begin
        t_load = t_done && (ref_due_q || req_valid);
        t_val  = ref_due_q ? cyc(dmc_pkg::C_FCS) : cyc(dmc_pkg::C_RAH);
      end
      ST_ROW: t_val = cyc(dmc_pkg::C_RAH);
      ST_COL: t_val = cyc(dmc_pkg::C_RAC);
      ST_ACC: t_val = (cur_q.op == dmc_pkg::DMC_OP_RMW) ? cyc(dmc_pkg::C_OFD + dmc_pkg::C_WP)
                                                         : cyc(dmc_pkg::C_CAS);
      ST_RCAS: t_val = cyc(dmc_pkg::C_RAS);
      default: t_load = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= ST_PAUSE;
      pause_done_q <= 1'b0;
      init_cnt_q <= '0;
      cur_q      <= '0;
      pins_q     <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
      dq_out_q   <= '0;
      dq_oe_n_q  <= 1'b1;
      rsp_q      <= '0;
      rsp_v_q    <= 1'b0;
    end else if (ce) begin
      rsp_v_q <= 1'b0;
      if (t_done) begin
        case (state_q)
          ST_PAUSE: begin
            if (pause_done_q) begin
              pins_q.ras_n <= 1'b0;
              state_q      <= ST_IRAS;
            end
            pause_done_q <= 1'b1;
          end
          ST_IRAS: begin
            pins_q.ras_n <= 1'b1;
            init_cnt_q   <= init_cnt_q + 4'h1;
            state_q      <= ST_IPRE;
          end
          ST_IPRE: begin
            if (init_cnt_q == 4'(dmc_pkg::INIT_CYCLES)) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_PAUSE;
            end
          end
          ST_IDLE: begin
            if (ref_due_q) begin
              pins_q.cas_n <= 1'b0;
              state_q      <= ST_RCAS;
            end else if (req_valid) begin
              cur_q       <= req;
              pins_q.addr <= req.addr[15:8];
              pins_q.we_n <= (req.op != dmc_pkg::DMC_OP_WRITE);
              dq_out_q    <= req.wdata;
              dq_oe_n_q   <= (req.op != dmc_pkg::DMC_OP_WRITE);
              state_q <= ST_ROW;
            end
          end
          ST_ROW: begin
            if (pins_q.ras_n) begin
              pins_q.ras_n <= 1'b0;
            end else begin
              pins_q.addr <= cur_q.addr[7:0];
              state_q     <= ST_COL;
            end
          end
          ST_COL: begin
            pins_q.cas_n <= 1'b0;
            pins_q.oe_n  <= (cur_q.op == dmc_pkg::DMC_OP_WRITE);
            state_q      <= ST_ACC;
          end
          ST_ACC: begin
            if (cur_q.op != dmc_pkg::DMC_OP_WRITE) begin
              rsp_q   <= dq_sync2_q;
              rsp_v_q <= 1'b1;
            end
            if (cur_q.op == dmc_pkg::DMC_OP_RMW) begin
              pins_q.oe_n <= 1'b1;
              state_q     <= ST_WEN;
            end else begin
              pins_q.cas_n <= 1'b1;
              pins_q.oe_n  <= 1'b1;
              state_q      <= ST_CLOSE;
            end
          end
          ST_WEN: begin
            if (dq_oe_n_q) begin
              dq_out_q  <= cur_q.wdata;
              dq_oe_n_q <= 1'b0;
            end else if (pins_q.we_n) begin
              pins_q.we_n <= 1'b0;
            end else begin
              pins_q.cas_n <= 1'b1;
              state_q      <= ST_CLOSE;
            end
          end
          ST_CLOSE: begin
            pins_q.we_n <= 1'b1;
            dq_oe_n_q   <= 1'b1;
            if (page_hit && req_valid) begin
              cur_q       <= req;
              pins_q.addr <= req.addr[7:0];
              pins_q.we_n <= (req.op != dmc_pkg::DMC_OP_WRITE);
              dq_out_q    <= req.wdata;
              dq_oe_n_q   <= (req.op != dmc_pkg::DMC_OP_WRITE);
              state_q <= ST_COL;
            end else begin
              pins_q.ras_n <= 1'b1;
              state_q      <= ST_PRE;
            end
          end
          ST_PRE: begin
            state_q <= ST_IDLE;
          end
          ST_RCAS: begin
            pins_q.ras_n <= 1'b0;
            state_q      <= ST_RRAS;
          end
          ST_RRAS: begin
            pins_q.ras_n <= 1'b1;
            pins_q.cas_n <= 1'b1;
            state_q      <= ST_PRE;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign pins      = pins_q;
  assign dq_out    = dq_out_q;
  assign dq_oe_n   = dq_oe_n_q;
  assign rsp_data  = rsp_q;
  assign rsp_valid = rsp_v_q;
  assign init_done = (state_q != ST_PAUSE) && (state_q != ST_IRAS) && (state_q != ST_IPRE);

  property p_cas_after_ras;
    $fell(pins_q.cas_n) && state_q == ST_ACC |-> !pins_q.ras_n;
  endproperty
  AST_CAS_GATED: assert property (p_cas_after_ras) else $error("column strobe fell before row");
  AST_EARLY_WE: assert property ($fell(pins_q.cas_n) && state_q == ST_ACC &&
    cur_q.op == dmc_pkg::DMC_OP_WRITE |-> !pins_q.we_n) else $error("early write enable not low");
  AST_OE_BEFORE_DATA: assert property ($fell(dq_oe_n_q) && state_q == ST_WEN |-> pins_q.oe_n)
    else $error("data driven with output enable low");
  AST_NO_CLASH: assert property (!dq_oe_n_q |-> pins_q.oe_n) else $error("bus clash on data pins");
  sequence s_cbr_start;
    $fell(pins_q.cas_n) && pins_q.ras_n && state_q == ST_RCAS;
  endsequence
  AST_CBR: assert property (s_cbr_start |-> pins_q.ras_n [*2])
    else $error("row strobe fell too early in refresh");
  AST_REF_SERVED: assert property ($rose(ref_due_q) |-> ##[1:200] (state_q == ST_RCAS))
    else $error("refresh not issued in time");
  AST_PAGE_RAS: assert property (state_q == ST_CLOSE && t_done && page_hit && req_valid |=> !pins_q.ras_n)
    else $error("row strobe rose in page mode");
  AST_INIT: assert property (!init_done |-> !req_ready) else $error("request accepted before init");
  AST_RSP: assert property (rsp_v_q |-> !pins_q.cas_n || !$past(pins_q.cas_n))
    else $error("read data taken without column strobe");
endmodule // dmc_ctrl

// ==== verif/dmc_dram_model.sv ====
module dmc_dram_model (
  input  wire dmc_pkg::dmc_pins_t         pins,
  input  wire logic [dmc_pkg::DATA_W-1:0] dq_bus,
  output logic [dmc_pkg::DATA_W-1:0]      dq_q,
  output logic                            dq_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [dmc_pkg::DATA_W-1:0] mem [0:65535];
  logic [dmc_pkg::DATA_W-1:0] last_q = 4'h0;
  logic [7:0]                 row_q = 8'h00;
  logic [7:0]                 col_q = 8'h00;
  logic [7:0]                 ref_q = 8'h00;
  logic                       cbr_q = 1'b0;
  logic                       ok_q  = 1'b0;
  logic                       wr_q  = 1'b0;
  int                         n_row = 0;
  int                         n_cbr = 0;
  longint                     t_first = -1;

  always @(negedge pins.ras_n) begin
    if (!pins.cas_n) begin
      row_q = ref_q;
      cbr_q = 1'b1;
      n_cbr++;
    end else begin
      row_q = pins.addr;
      cbr_q = 1'b0;
      n_row++;
    end
    if (t_first < 0)
      t_first = $time;
  end

  always @(posedge pins.ras_n)
    if (cbr_q)
      ref_q = ref_q + 8'h01;

  // gated: a column fall with row strobe high only arms refresh
  always @(negedge pins.cas_n) begin
    if (!pins.ras_n) begin
      col_q = pins.addr;
      wr_q  = !pins.we_n;
      if (wr_q)
        mem[{row_q, col_q}] = dq_bus;
      #75;
      if (!pins.cas_n && !wr_q)
        ok_q = 1'b1;
    end
  end

  always @(negedge pins.we_n)
    if (!pins.ras_n && !pins.cas_n)
      mem[{row_q, col_q}] = dq_bus;

  always @(posedge pins.cas_n)
    ok_q = 1'b0;

  assign dq_en = ok_q && !pins.cas_n && !pins.oe_n;
  // floating lines show the inverse so a stale value never passes
  assign dq_q = dq_en ? mem[{row_q, col_q}] : ~last_q;

  always @(dq_q)
    if (dq_en)
      last_q = dq_q;
endmodule // dmc_dram_model

// ==== verif/dmc_ctrl_test.sv ====
module dmc_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PAUSE = 20;
  localparam int REFI  = 100;
  logic                       clk = 1'b0;
  logic                       rstn = 1'b0;
  logic                       ce = 1'b1;
  logic                       req_valid = 1'b0;
  logic                       req_ready;
  dmc_pkg::dmc_req_t          req = '0;
  logic                       page_hold = 1'b0;
  logic                       rsp_valid;
  logic [dmc_pkg::DATA_W-1:0] rsp_data;
  logic                       init_done;
  dmc_pkg::dmc_pins_t         pins;
  logic [dmc_pkg::DATA_W-1:0] dq_in;
  logic [dmc_pkg::DATA_W-1:0] dq_out;
  logic [dmc_pkg::DATA_W-1:0] m_q;
  logic                       dq_oe_n;
  logic                       m_en;
  int                         bad_count = 0;
  int                         compares = 0;
  int                         clash = 0;
  longint                     rel_t = 0;
  logic [15:0]                ta [0:4] = '{16'h1234, 16'h3412, 16'hFF00, 16'h00FF, 16'h12F0};
  logic [3:0]                 td [0:4] = '{4'hA, 4'h5, 4'hF, 4'h0, 4'h6};

  always #12.5 clk = ~clk;
  assign dq_in = !dq_oe_n ? dq_out : m_q;
  always @(negedge clk)
    if (!dq_oe_n && m_en)
      clash++;

  dmc_ctrl #(.INIT_PAUSE_CYC(PAUSE), .REF_INT_CYC(REFI)) uut (
    .clk(clk), .rstn(rstn), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .page_hold(page_hold), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .init_done(init_done), .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  dmc_dram_model m (.pins(pins), .dq_bus(dq_in), .dq_q(m_q), .dq_en(m_en));

  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait at falling edges for ready, response or init
  task automatic wait_for(input int which);
    int n;
    n = 0;
    while (n < 3000 && (which == 0 ? req_ready : which == 1 ? rsp_valid : init_done) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, 16'h0, 16'h1);
      finish_test();
    end
  endtask

  task automatic send(input dmc_pkg::dmc_op_t op, input logic [15:0] a, input logic [3:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op, a, d};
    wait_for(0);
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic t_init();
    wait_for(2);
    check(16'(m.n_row + m.n_cbr >= 8), 16'h1);
    check(16'(m.t_first >= rel_t + PAUSE * 25), 16'h1);
  endtask

  task automatic t_rw();
    for (int i = 0; i < 5; i++) begin
      send(dmc_pkg::DMC_OP_WRITE, ta[i], td[i]);
      wait_for(0);
      check(16'(m.mem[ta[i]]), 16'(td[i]));
    end
    for (int i = 0; i < 5; i++) begin
      send(dmc_pkg::DMC_OP_READ, ta[i], 4'h0);
      wait_for(1);
      check(16'(rsp_data), 16'(td[i]));
    end
  endtask

  task automatic t_rmw();
    send(dmc_pkg::DMC_OP_RMW, ta[0], 4'h3);
    wait_for(1);
    check(16'(rsp_data), 16'hA);
    wait_for(0);
    check(16'(m.mem[ta[0]]), 16'h3);
    check(16'(clash), 16'h0);
  endtask

  // starts just after a refresh so none closes the open row
  task automatic t_page();
    int c;
    int r;
    c = m.n_cbr;
    for (int n = 0; n < 400 && m.n_cbr == c; n++)
      @(negedge clk);
    if (m.n_cbr == c)
      check(16'h0, 16'h1);
    page_hold = 1'b1;
    r = m.n_row;
    send(dmc_pkg::DMC_OP_READ, ta[0], 4'h0);
    wait_for(1);
    check(16'(rsp_data), 16'h3);
    send(dmc_pkg::DMC_OP_READ, ta[4], 4'h0);
    wait_for(1);
    check(16'(rsp_data), 16'h6);
    check(16'(m.n_row - r), 16'h1);
    @(negedge clk);
    page_hold = 1'b0;
  endtask

  task automatic t_refresh();
    int c;
    int r;
    dmc_pkg::dmc_pins_t p;
    wait_for(0);
    // frozen clock enable: pins hold and no refresh starts across a whole interval
    ce = 1'b0;
    p = pins;
    c = m.n_cbr;
    repeat (150) @(negedge clk);
    check(16'(pins), 16'(p));
    check(16'(m.n_cbr - c), 16'h0);
    ce = 1'b1;
    c = m.n_cbr;
    r = m.n_row;
    repeat (1000) @(negedge clk);
    check(16'(m.n_cbr - c >= 1000 / REFI - 1), 16'h1);
    check(16'(m.n_row - r), 16'h0);
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    rel_t = $time;
    t_init();
    t_rw();
    t_rmw();
    t_page();
    t_refresh();
    check(16'(clash), 16'h0);
    finish_test();
  end
endmodule // dmc_ctrl_test
